// file: inc/aercs_pkg.sv
// constants and carrier types for the error severity and correctable status bank
package aercs_pkg;

  // byte addresses on the register bus
  localparam logic [11:0] ADDR_SEVERITY   = 12'h10c;
  localparam logic [11:0] ADDR_COR_STATUS = 12'h110;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h140;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h144;
  localparam logic [11:0] ADDR_IRQ_CLEAR  = 12'h148;

  // severity selector positions
  localparam int SEV_ECRC_BIT = 19;
  localparam int SEV_UR_BIT   = 20;
  localparam int SEV_ACS_BIT  = 21;
  localparam int SEV_DBE_BIT  = 31;

  // correctable status positions
  localparam int COR_RCV_BIT     = 0;
  localparam int COR_TLP_BIT     = 6;
  localparam int COR_DLLP_BIT    = 7;
  localparam int COR_ROLL_BIT    = 8;
  localparam int COR_TIMEOUT_BIT = 12;
  localparam int COR_ADV_BIT     = 13;
  localparam int COR_SBE_BIT     = 31;

  // implemented bits and reset values
  localparam logic [31:0] SEV_IMPL  = 32'h8038_0000;
  localparam logic [31:0] SEV_RESET = 32'h0000_0000;
  localparam logic [31:0] COR_IMPL  = 32'h8000_31c1;
  localparam logic [31:0] COR_RESET = 32'h0000_0000;

  // interrupt status layout
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_FATAL_BIT = 0;
  localparam int          IRQ_NONF_BIT  = 1;
  localparam int          IRQ_COR_BIT   = 2;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

  // uncorrectable events with a severity selector here
  typedef struct packed {
    logic ecrc;
    logic ur;
    logic acs;
    logic dbe;
  } aercs_unc_evt_t;

  // correctable events
  typedef struct packed {
    logic rcv;
    logic bad_tlp;
    logic bad_dllp;
    logic rollover;
    logic timeout;
    logic advisory;
    logic single_bit_memory_error;
  } aercs_cor_evt_t;

endpackage : aercs_pkg

// file: rtl/aercs_regs.sv
// error severity selectors and correctable status bank with wishbone slave
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// RULE_01 - severity bits 19, 20, 21 and 31 are writable selectors
// RULE_02 - unmasked uncorrectable event with selector one reports fatal
// RULE_03 - unmasked uncorrectable event with selector zero reports non-fatal
// RULE_04 - masked uncorrectable events report at neither severity
// RULE_05 - double-bit selector reads zero, ignores writes without double-bit enable
// RULE_06 - selectors reset to zero; bits 30 to 22 read zero
// RULE_07 - receiver error sets status bit 0
// RULE_08 - bad packet sets status bit 6
// RULE_09 - bad link packet sets status bit 7
// RULE_10 - replay number rollover sets status bit 8
// RULE_11 - replay timer expiry sets status bit 12
// RULE_12 - advisory non-fatal condition sets status bit 13
// RULE_13 - single-bit memory error sets bit 31 while single-bit enable set
// RULE_14 - status bit 31 reads zero, unwritable without single-bit enable
// RULE_15 - correctable event masked in its mask bit is not reported
// RULE_16 - double-bit enable gates double-bit errors out of reporting entirely
// RULE_17 - status bits reset zero, clear on write one, reserved read zero
// RULE_18 - sticky bits survive hot reset, cleared only by power-on reset
module aercs_regs (
  // clock and power-on reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // hot or link-down reset, spares sticky bits
  input  wire logic                    hot_reset_i,
  // wishbone slave
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [11:0]             wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [31:0]             wb_dat_i,
  output logic      [31:0]             wb_dat_o,
  output logic                         wb_ack_o,
  // masks and memory error control
  input  wire logic [31:0]             uncor_mask_i,
  input  wire logic [31:0]             cor_mask_i,
  input  wire logic                    double_bit_report_enable_i,
  input  wire logic                    single_bit_report_enable_i,
  // error events, one-cycle pulses
  input  wire aercs_pkg::aercs_unc_evt_t unc_evt_i,
  input  wire aercs_pkg::aercs_cor_evt_t cor_evt_i,
  // reports and interrupt
  output logic                         fatal_report_o,
  output logic                         nonfatal_report_o,
  output logic                         correctable_report_o,
  output logic                         irq_o
);

  logic                        ack_reg;
  logic [31:0]                 dat_reg;
  logic [31:0]                 sev_reg;
  logic [31:0]                 sev_next;
  logic [31:0]                 cor_reg;
  logic [31:0]                 cor_next;
  logic [31:0]                 cor_set;
  logic [31:0]                 cor_clr;
  logic [31:0]                 unc_vec;
  logic [31:0]                 cor_vec;
  logic [31:0]                 unc_live;
  logic [31:0]                 cor_live;
  logic [31:0]                 wmask;
  logic [aercs_pkg::IRQ_W-1:0] ist_reg;
  logic [aercs_pkg::IRQ_W-1:0] ist_next;
  logic [aercs_pkg::IRQ_W-1:0] ien_reg;
  logic [aercs_pkg::IRQ_W-1:0] irq_set;
  logic                        fatal_reg;
  logic                        nonf_reg;
  logic                        corr_reg;
  logic                        irq_reg;
  logic                        req;
  logic                        wr_fire;
  logic                        sev_wr;
  logic                        cor_wr;
  logic                        ien_wr;
  logic                        iclr_wr;
  logic                        dbe_en;
  logic                        sbe_en;

  assign dbe_en = double_bit_report_enable_i;
  assign sbe_en = single_bit_report_enable_i;

  // bus decode; a write lands on the edge where ack is sampled
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_reg;
  assign sev_wr  = wr_fire & (wb_adr_i == aercs_pkg::ADDR_SEVERITY);
  assign cor_wr  = wr_fire & (wb_adr_i == aercs_pkg::ADDR_COR_STATUS);
  assign ien_wr  = wr_fire & (wb_adr_i == aercs_pkg::ADDR_IRQ_ENABLE);
  assign iclr_wr = wr_fire & (wb_adr_i == aercs_pkg::ADDR_IRQ_CLEAR);
  assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i || hot_reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // read data captured with the request; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i || hot_reset_i) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      unique case (wb_adr_i)
        aercs_pkg::ADDR_SEVERITY:   dat_reg <= sev_reg & aercs_pkg::SEV_IMPL; // RULE_06
        aercs_pkg::ADDR_COR_STATUS: dat_reg <= cor_reg & aercs_pkg::COR_IMPL; // RULE_17
        aercs_pkg::ADDR_IRQ_STATUS: dat_reg <= {29'h0000_0000, ist_reg};
        aercs_pkg::ADDR_IRQ_ENABLE: dat_reg <= {29'h0000_0000, ien_reg};
        default:                    dat_reg <= 32'h0000_0000;
      endcase
    end
  end

  // event vectors in register layout
  always_comb begin
    unc_vec = 32'h0000_0000;
    unc_vec[aercs_pkg::SEV_ECRC_BIT] = unc_evt_i.ecrc;
    unc_vec[aercs_pkg::SEV_UR_BIT]   = unc_evt_i.ur;
    unc_vec[aercs_pkg::SEV_ACS_BIT]  = unc_evt_i.acs;
    unc_vec[aercs_pkg::SEV_DBE_BIT]  = unc_evt_i.dbe & dbe_en; // RULE_16
    cor_vec = 32'h0000_0000;
    cor_vec[aercs_pkg::COR_RCV_BIT]     = cor_evt_i.rcv;      // RULE_07
    cor_vec[aercs_pkg::COR_TLP_BIT]     = cor_evt_i.bad_tlp;  // RULE_08
    cor_vec[aercs_pkg::COR_DLLP_BIT]    = cor_evt_i.bad_dllp; // RULE_09
    cor_vec[aercs_pkg::COR_ROLL_BIT]    = cor_evt_i.rollover; // RULE_10
    cor_vec[aercs_pkg::COR_TIMEOUT_BIT] = cor_evt_i.timeout;  // RULE_11
    cor_vec[aercs_pkg::COR_ADV_BIT]     = cor_evt_i.advisory; // RULE_12
    cor_vec[aercs_pkg::COR_SBE_BIT]     = cor_evt_i.single_bit_memory_error & sbe_en; // RULE_13
  end

  // severity selectors
  always_comb begin
    sev_next = sev_reg;
    if (sev_wr) begin
      sev_next = ((sev_reg & ~wmask) | (wb_dat_i & wmask)) & aercs_pkg::SEV_IMPL; // RULE_01
    end
    if (!dbe_en) begin
      sev_next[aercs_pkg::SEV_DBE_BIT] = 1'b0; // RULE_05
    end
  end

  // sticky: only power-on reset clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sev_reg <= aercs_pkg::SEV_RESET; // RULE_06 RULE_18
    end else begin
      sev_reg <= sev_next;
    end
  end

  // correctable status, set wins over write-one clear
  assign cor_set = cor_vec & aercs_pkg::COR_IMPL;
  assign cor_clr = cor_wr ? (wb_dat_i & wmask) : 32'h0000_0000;

  for (genvar i = 0; i < 32; i++) begin : g_cor
    if (!aercs_pkg::COR_IMPL[i]) begin : g_rsvd
      assign cor_next[i] = 1'b0;
    end else if (i == aercs_pkg::COR_SBE_BIT) begin : g_sbe
      assign cor_next[i] = sbe_en & (cor_set[i] | (cor_reg[i] & ~cor_clr[i])); // RULE_14
    end else begin : g_evt
      assign cor_next[i] = cor_set[i] | (cor_reg[i] & ~cor_clr[i]); // RULE_17
    end
  end

  // sticky: only power-on reset clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cor_reg <= aercs_pkg::COR_RESET; // RULE_18
    end else begin
      cor_reg <= cor_next;
    end
  end

  // error reporting toward the root complex
  assign unc_live = unc_vec & ~uncor_mask_i & aercs_pkg::SEV_IMPL; // RULE_04
  assign cor_live = cor_set & ~cor_mask_i; // RULE_15

  always_ff @(posedge clk_i) begin
    if (rst_i || hot_reset_i) begin
      fatal_reg <= 1'b0;
      nonf_reg  <= 1'b0;
      corr_reg  <= 1'b0;
    end else begin
      fatal_reg <= |(unc_live & sev_reg);  // RULE_02
      nonf_reg  <= |(unc_live & ~sev_reg); // RULE_03
      corr_reg  <= |cor_live;
    end
  end

  // interrupt status, enable and clear
  always_comb begin
    irq_set = aercs_pkg::IRQ_RESET;
    irq_set[aercs_pkg::IRQ_FATAL_BIT] = fatal_reg;
    irq_set[aercs_pkg::IRQ_NONF_BIT]  = nonf_reg;
    irq_set[aercs_pkg::IRQ_COR_BIT]   = corr_reg;
    ist_next = ist_reg;
    if (iclr_wr) begin
      ist_next = ist_reg & ~wb_dat_i[aercs_pkg::IRQ_W-1:0];
    end
    ist_next = ist_next | irq_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hot_reset_i) begin
      ist_reg <= aercs_pkg::IRQ_RESET;
    end else begin
      ist_reg <= ist_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hot_reset_i) begin
      ien_reg <= aercs_pkg::IRQ_RESET;
    end else if (ien_wr && wb_sel_i[0]) begin
      ien_reg <= wb_dat_i[aercs_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || hot_reset_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(ist_reg & ien_reg);
    end
  end

  assign wb_ack_o             = ack_reg;
  assign wb_dat_o             = dat_reg;
  assign fatal_report_o       = fatal_reg;
  assign nonfatal_report_o    = nonf_reg;
  assign correctable_report_o = corr_reg;
  assign irq_o                = irq_reg;

  // checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  chk_sev_write: assert property ( // RULE_01
    sev_wr && wb_sel_i[2] |=> sev_reg[21:19] == $past(wb_dat_i[21:19]))
    else $error("severity selectors did not take the write");

  chk_fatal_path: assert property ( // RULE_02
    !hot_reset_i && unc_evt_i.ecrc && !uncor_mask_i[aercs_pkg::SEV_ECRC_BIT]
      && sev_reg[aercs_pkg::SEV_ECRC_BIT] |=> fatal_report_o)
    else $error("unmasked event with selector set not fatal");

  chk_nonfatal_path: assert property ( // RULE_03
    !hot_reset_i && unc_evt_i.acs && !uncor_mask_i[aercs_pkg::SEV_ACS_BIT]
      && !sev_reg[aercs_pkg::SEV_ACS_BIT] |=> nonfatal_report_o)
    else $error("unmasked event with selector clear not non-fatal");

  chk_unc_masked: assert property ( // RULE_04
    (unc_vec & ~uncor_mask_i & aercs_pkg::SEV_IMPL) == 32'h0000_0000
      |=> !fatal_report_o && !nonfatal_report_o)
    else $error("masked uncorrectable event was reported");

  chk_dbe_gate: assert property ( // RULE_05
    !dbe_en |=> !sev_reg[aercs_pkg::SEV_DBE_BIT])
    else $error("double-bit selector set without enable");

  chk_sev_rsvd: assert property ( // RULE_06
    wb_ack_o && !wb_we_i && wb_adr_i == aercs_pkg::ADDR_SEVERITY
      |-> wb_dat_o[30:22] == 9'h000)
    else $error("severity reserved bits read nonzero");

  chk_rcv_set: assert property ( // RULE_07
    cor_evt_i.rcv |=> cor_reg[aercs_pkg::COR_RCV_BIT])
    else $error("receiver error not latched");

  chk_tlp_set: assert property ( // RULE_08
    cor_evt_i.bad_tlp |=> cor_reg[aercs_pkg::COR_TLP_BIT])
    else $error("bad packet not latched");

  chk_dllp_set: assert property ( // RULE_09
    cor_evt_i.bad_dllp |=> cor_reg[aercs_pkg::COR_DLLP_BIT])
    else $error("bad link packet not latched");

  chk_roll_set: assert property ( // RULE_10
    cor_evt_i.rollover |=> cor_reg[aercs_pkg::COR_ROLL_BIT])
    else $error("replay rollover not latched");

  chk_timeout_set: assert property ( // RULE_11
    cor_evt_i.timeout |=> cor_reg[aercs_pkg::COR_TIMEOUT_BIT])
    else $error("replay timeout not latched");

  chk_adv_set: assert property ( // RULE_12
    cor_evt_i.advisory |=> cor_reg[aercs_pkg::COR_ADV_BIT])
    else $error("advisory error not latched");

  chk_sbe_set: assert property ( // RULE_13
    sbe_en && cor_evt_i.single_bit_memory_error ##1 sbe_en |-> cor_reg[aercs_pkg::COR_SBE_BIT])
    else $error("single-bit error not latched");

  chk_sbe_gate: assert property ( // RULE_14
    !sbe_en |=> !cor_reg[aercs_pkg::COR_SBE_BIT])
    else $error("single-bit status set without enable");

  chk_cor_masked: assert property ( // RULE_15
    (cor_set & ~cor_mask_i) == 32'h0000_0000 |=> !correctable_report_o)
    else $error("masked correctable event was reported");

  chk_w1c_hold: assert property ( // RULE_17
    cor_reg[aercs_pkg::COR_RCV_BIT] && !(cor_wr && wb_sel_i[0] && wb_dat_i[0])
      |=> cor_reg[aercs_pkg::COR_RCV_BIT])
    else $error("status bit lost without a clear");

  chk_sticky_hot: assert property ( // RULE_18
    hot_reset_i && sbe_en && dbe_en && cor_set == 32'h0000_0000 && !cor_wr && !sev_wr
      |=> cor_reg == $past(cor_reg) && sev_reg == $past(sev_reg))
    else $error("sticky bits disturbed by hot reset");

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  cov_fatal: cover property (fatal_report_o);
  cov_nonfatal: cover property (nonfatal_report_o);
  cov_cor_clear: cover property (cor_reg[0] ##1 !cor_reg[0]);
  cov_irq: cover property (!irq_o ##1 irq_o);

endmodule : aercs_regs
`default_nettype wire

// file: tb/aercs_regs_tb.sv
// self-checking bench for the severity and correctable status bank
`timescale 1ns/100ps
`default_nettype none
module aercs_regs_tb;
  logic                      clk_i = 1'b0;
  logic                      rst_i = 1'b1;
  logic                      hot_reset_i = 1'b0;
  logic                      wb_cyc_i = 1'b0;
  logic                      wb_stb_i = 1'b0;
  logic                      wb_we_i = 1'b0;
  logic [11:0]               wb_adr_i = 12'h000;
  logic [3:0]                wb_sel_i = 4'h0;
  logic [31:0]               wb_dat_i = 32'h0000_0000;
  logic [31:0]               wb_dat_o;
  logic                      wb_ack_o;
  logic [31:0]               uncor_mask_i = 32'h0000_0000;
  logic [31:0]               cor_mask_i = 32'h0000_0000;
  logic                      dbl_en = 1'b1;
  logic                      sgl_en = 1'b1;
  aercs_pkg::aercs_unc_evt_t unc_evt_i = '0;
  aercs_pkg::aercs_cor_evt_t cor_evt_i = '0;
  logic                      fatal_o, nonf_o, cor_o, irq_o;
  int                        n_fail = 0;
  int                        check_count = 0;
  int                        unc_pos [4] = '{31, 21, 20, 19};
  int                        cor_pos [7] = '{31, 13, 12, 8, 7, 6, 0};
  logic [31:0]               sev_pat [2] = '{32'h8028_0000, 32'h0010_0000};
  logic [2:0]                r;

  always #25 clk_i = ~clk_i;

  aercs_regs i_aercs_regs (
    .clk_i(clk_i), .rst_i(rst_i), .hot_reset_i(hot_reset_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .uncor_mask_i(uncor_mask_i), .cor_mask_i(cor_mask_i),
    .double_bit_report_enable_i(dbl_en), .single_bit_report_enable_i(sgl_en),
    .unc_evt_i(unc_evt_i), .cor_evt_i(cor_evt_i), .fatal_report_o(fatal_o),
    .nonfatal_report_o(nonf_o), .correctable_report_o(cor_o), .irq_o(irq_o)
  );

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk32

  task automatic chk3(input string nm, input logic [2:0] e, input logic [2:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk3

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    chk32("wb_latency", 32'h0000_0002, n);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, 4'hf, d, x);
  endtask : wr

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    logic [31:0] x;
    wb(1'b0, a, 4'hf, 32'h0, x);
    chk32(nm, e, x);
  endtask : rdc

  // one-cycle event pulse, reports sampled in the following cycle
  task automatic ev(input logic [3:0] u, input logic [6:0] c, output logic [2:0] rep);
    @(posedge clk_i);
    unc_evt_i <= u;
    cor_evt_i <= c;
    @(posedge clk_i);
    unc_evt_i <= '0;
    cor_evt_i <= '0;
    @(negedge clk_i);
    rep = {fatal_o, nonf_o, cor_o};
  endtask : ev

  task automatic t_reset;
    rdc("severity", aercs_pkg::ADDR_SEVERITY, 32'h0);
    rdc("cor_status", aercs_pkg::ADDR_COR_STATUS, 32'h0);
    rdc("unmapped", 12'hffc, 32'h0);
  endtask : t_reset

  task automatic t_severity;
    logic [31:0] x;
    wr(aercs_pkg::ADDR_SEVERITY, 32'hffff_ffff);
    rdc("severity", aercs_pkg::ADDR_SEVERITY, 32'h8038_0000);
    wr(aercs_pkg::ADDR_SEVERITY, 32'h0);
    wb(1'b1, aercs_pkg::ADDR_SEVERITY, 4'h4, 32'hffff_ffff, x);
    rdc("severity", aercs_pkg::ADDR_SEVERITY, 32'h0038_0000);
    wr(aercs_pkg::ADDR_SEVERITY, 32'hffff_ffff);
    dbl_en <= 1'b0;
    rdc("severity", aercs_pkg::ADDR_SEVERITY, 32'h0038_0000);
    wr(aercs_pkg::ADDR_SEVERITY, 32'hffff_ffff);
    rdc("severity", aercs_pkg::ADDR_SEVERITY, 32'h0038_0000);
    dbl_en <= 1'b1;
    rdc("severity", aercs_pkg::ADDR_SEVERITY, 32'h0038_0000);
  endtask : t_severity

  task automatic t_unc;
    logic f;
    for (int p = 0; p < 2; p++) begin
      wr(aercs_pkg::ADDR_SEVERITY, sev_pat[p]);
      for (int i = 0; i < 4; i++) begin
        f = sev_pat[p][unc_pos[i]];
        ev(4'(1) << i, 7'h0, r);
        chk3("unc_report", {f, ~f, 1'b0}, r);
      end
    end
    @(posedge clk_i);
    uncor_mask_i <= 32'hffff_ffff;
    for (int i = 0; i < 4; i++) begin
      ev(4'(1) << i, 7'h0, r);
      chk3("masked_report", 3'b000, r);
    end
    @(posedge clk_i);
    uncor_mask_i <= 32'h0;
    dbl_en <= 1'b0;
    ev(4'h1, 7'h0, r);
    chk3("dbe_disabled", 3'b000, r);
    @(posedge clk_i);
    dbl_en <= 1'b1;
  endtask : t_unc

  task automatic t_cor;
    for (int i = 0; i < 7; i++) begin
      ev(4'h0, 7'(1) << i, r);
      chk3("cor_report", 3'b001, r);
      rdc("cor_status", aercs_pkg::ADDR_COR_STATUS, 32'h1 << cor_pos[i]);
      wr(aercs_pkg::ADDR_COR_STATUS, 32'h0);
      rdc("cor_kept", aercs_pkg::ADDR_COR_STATUS, 32'h1 << cor_pos[i]);
      wr(aercs_pkg::ADDR_COR_STATUS, 32'hffff_ffff);
      rdc("cor_cleared", aercs_pkg::ADDR_COR_STATUS, 32'h0);
    end
    cor_mask_i <= 32'hffff_ffff;
    ev(4'h0, 7'h7f, r);
    chk3("cor_masked", 3'b000, r);
    rdc("cor_status", aercs_pkg::ADDR_COR_STATUS, 32'h8000_31c1);
    sgl_en <= 1'b0;
    rdc("sbe_hidden", aercs_pkg::ADDR_COR_STATUS, 32'h0000_31c1);
    ev(4'h0, 7'h01, r);
    rdc("sbe_ignored", aercs_pkg::ADDR_COR_STATUS, 32'h0000_31c1);
    sgl_en <= 1'b1;
    cor_mask_i <= 32'h0;
    wr(aercs_pkg::ADDR_COR_STATUS, 32'hffff_ffff);
  endtask : t_cor

  task automatic t_sticky;
    wr(aercs_pkg::ADDR_SEVERITY, 32'h8038_0000);
    ev(4'h0, 7'h7f, r);
    @(posedge clk_i);
    hot_reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    hot_reset_i <= 1'b0;
    rdc("sev_hot", aercs_pkg::ADDR_SEVERITY, 32'h8038_0000);
    rdc("cor_hot", aercs_pkg::ADDR_COR_STATUS, 32'h8000_31c1);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("sev_por", aercs_pkg::ADDR_SEVERITY, 32'h0);
    rdc("cor_por", aercs_pkg::ADDR_COR_STATUS, 32'h0);
  endtask : t_sticky

  task automatic t_irq;
    wr(aercs_pkg::ADDR_IRQ_ENABLE, 32'h4);
    ev(4'h0, 7'h20, r);
    rdc("irq_status", aercs_pkg::ADDR_IRQ_STATUS, 32'h4);
    chk32("irq_on", 32'h1, {31'h0, irq_o});
    wr(aercs_pkg::ADDR_IRQ_ENABLE, 32'h0);
    rdc("irq_enable", aercs_pkg::ADDR_IRQ_ENABLE, 32'h0);
    chk32("irq_masked", 32'h0, {31'h0, irq_o});
    wr(aercs_pkg::ADDR_IRQ_ENABLE, 32'h7);
    rdc("irq_enable", aercs_pkg::ADDR_IRQ_ENABLE, 32'h7);
    chk32("irq_on", 32'h1, {31'h0, irq_o});
    wr(aercs_pkg::ADDR_IRQ_CLEAR, 32'h4);
    rdc("irq_status", aercs_pkg::ADDR_IRQ_STATUS, 32'h0);
    chk32("irq_off", 32'h0, {31'h0, irq_o});
  endtask : t_irq

  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_severity();
    t_unc();
    t_cor();
    t_sticky();
    t_irq();
    final_report();
  end

  // about 260 cycles expected; cut a hang well beyond that
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    $display("ERROR watchdog expected done seen running");
    final_report();
  end
endmodule : aercs_regs_tb
`default_nettype wire
